// ### pkg/pin_route_pkg.sv
// Package of constants, bus carriers and state codes for the remappable pin output router.
package pin_route_pkg;

    // Register byte offsets on the APB port.
    localparam int          ADDR_W          = 12;
    localparam logic [11:0] OSC_CTRL_ADDR   = 12'h000;
    localparam logic [11:0] OSC_CFG_ADDR    = 12'h004;
    localparam logic [11:0] STATUS_ADDR     = 12'h008;
    localparam logic [11:0] IN_ROUTE_BASE   = 12'h100;
    localparam logic [11:0] OUT_ROUTE_BASE  = 12'h200;
    localparam logic [11:0] ROUTE_SPAN      = 12'h100;

    // Field positions.
    localparam int          SEL_W           = 6;
    localparam int          FIELD_LO_POS    = 0;
    localparam int          FIELD_HI_POS    = 8;
    localparam int          LOCK_BIT_POS    = 6;
    localparam int          FUSE_BIT_POS    = 5;
    localparam int          MISMATCH_POS    = 0;

    // Unlock keys written to the low byte of the control word.
    localparam logic [7:0]  UNLOCK_KEY_ONE  = 8'h46;
    localparam logic [7:0]  UNLOCK_KEY_TWO  = 8'h57;

    // Selector codes and reset values.
    localparam logic [5:0]  SEL_NULL        = 6'h00;
    localparam logic [5:0]  IN_SEL_RESET    = 6'h3f;
    localparam logic [5:0]  OUT_SEL_RESET   = 6'h00;
    localparam logic [5:0]  GROUP_A_FIRST   = 6'h01;
    localparam logic [5:0]  GROUP_A_LAST    = 6'h0c;
    localparam logic [5:0]  GROUP_B_FIRST   = 6'h10;
    localparam logic [5:0]  GROUP_B_LAST    = 6'h23;
    localparam int          PERIPH_OUT_W    = 36;
    localparam logic [5:0]  INPUT_ONLY_PIN  = 6'h25;
    localparam logic        LOCK_RESET      = 1'b0;
    localparam logic        FUSE_RESET      = 1'b1;

    // Defaults for the largest variant.
    localparam int          MAX_PINS        = 32;
    localparam int          DEF_INPUTS      = 38;

    // APB request from the master.
    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [11:0]       paddr;
        logic [31:0]       pwdata;
    } apb_req_type;

    // APB answer to the master.
    typedef struct packed {
        logic              pready;
        logic              pslverr;
        logic [31:0]       prdata;
    } apb_rsp_type;

    // Progress through the unlock sequence.
    typedef enum logic [1:0] {
        UNLOCK_IDLE = 2'b00,
        UNLOCK_KEY1 = 2'b01,
        UNLOCK_KEY2 = 2'b10
    } unlock_state_type;

endpackage

// ### hw/pin_out_selector.sv
// One remappable pin's output selector: picks a peripheral output by code.
`timescale 1ns/1ps
module pin_out_selector (
    // Clock and reset.
    input  wire logic                               clk,
    input  wire logic                               rstn,
    // Selection.
    input  wire logic [pin_route_pkg::SEL_W-1:0]    sel,
    input  wire logic [pin_route_pkg::PERIPH_OUT_W-1:0] periph_out,
    // Pin drive.
    output logic                                    pin_out,
    output logic                                    pin_oe
);
    import pin_route_pkg::*;

    logic valid_code;

    // Codes 13 to 15 and above 35 behave like the null code.
    assign valid_code = ((sel >= GROUP_A_FIRST) && (sel <= GROUP_A_LAST)) ||
                        ((sel >= GROUP_B_FIRST) && (sel <= GROUP_B_LAST));

    // Registered drive keeps glitches from the selector off the pad.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_out <= 1'b0;
            pin_oe  <= 1'b0;
        end else begin
            pin_oe  <= valid_code;
            pin_out <= valid_code ? periph_out[sel] : 1'b0;
        end
    end

endmodule

// ### hw/pin_route_top.sv
// Remappable pin router: APB registers, unlock sequence, shadows, input and output routing.
//
// Summary of operation
// - Six-bit output selector per pin, two per register.
// - Code zero leaves the pin undriven.
// - Codes 1 to 12 select first peripheral group.
// - Codes 16 to 35 select second peripheral group.
// - Any input or output may fan out freely.
// - Input code for missing pin gives no input.
// - Output fields of missing pins ignore writes.
// - Locked routing writes complete but change nothing.
// - Lock bit is control word bit 6.
// - Keys 46h, 57h, then lock write.
// - Lock holds its value until changed again.
// - Shadow copies mismatch raises a reset request.
// - One-way fuse makes lock permanent once set.
// - Unprogrammed fuse reads set, allowing one session.
// - Pin count per variant, plus one input-only pin.
// - Reset: input fields ones, output fields zeros.
// - Each peripheral input has its own pin selector.
// - Lock comes out of reset unlocked.
`timescale 1ns/1ps
module pin_route_top #(
    parameter int NUM_PINS   = pin_route_pkg::MAX_PINS,
    parameter int NUM_INPUTS = pin_route_pkg::DEF_INPUTS
) (
    // Clock and reset.
    input  wire logic                                   clk,
    input  wire logic                                   rstn,
    // APB slave port.
    input  wire pin_route_pkg::apb_req_type             apb_req,
    output pin_route_pkg::apb_rsp_type                  apb_rsp,
    // Configuration fuse level, from outside the clock domain.
    input  wire logic                                   single_session_lock_fuse,
    // Remappable pins.
    input  wire logic [pin_route_pkg::MAX_PINS-1:0]     remappable_io_pin_in,
    input  wire logic                                   remappable_input_pin,
    output logic      [pin_route_pkg::MAX_PINS-1:0]     remappable_io_pin_out,
    output logic      [pin_route_pkg::MAX_PINS-1:0]     remappable_io_pin_oe,
    // Peripheral side.
    input  wire logic [pin_route_pkg::PERIPH_OUT_W-1:0] periph_out,
    output logic      [NUM_INPUTS-1:0]                  periph_in,
    // Reset request on a shadow mismatch.
    output logic                                        config_mismatch_reset
);
    import pin_route_pkg::*;

    localparam int IN_REGS  = (NUM_INPUTS + 1) / 2;
    localparam int OUT_REGS = MAX_PINS / 2;

    logic [SEL_W-1:0]     in_sel_reg   [NUM_INPUTS];
    logic [SEL_W-1:0]     in_shadow_reg[NUM_INPUTS];
    logic [SEL_W-1:0]     out_sel_reg  [MAX_PINS];
    logic [SEL_W-1:0]     out_shadow_reg[MAX_PINS];
    logic                 route_write_lock_reg;
    logic                 lock_set_once_reg;
    logic                 mismatch_seen_reg;
    logic                 fuse_meta_reg;
    logic                 fuse_reg;
    logic [MAX_PINS-1:0]  pin_meta_reg;
    logic [MAX_PINS-1:0]  pin_sync_reg;
    logic                 in_only_meta_reg;
    logic                 in_only_sync_reg;
    logic [31:0]          prdata_reg;
    logic                 pslverr_reg;
    unlock_state_type     unlock_state_reg;
    unlock_state_type     unlock_state_next;
    logic                 wr_en;
    logic                 rd_setup;
    logic                 hit_ctrl;
    logic                 hit_in;
    logic                 hit_out;
    logic [6:0]           word_idx;
    logic                 route_wr_ok;
    logic                 shadow_diff;
    logic [31:0]          rdata_next;
    logic                 mapped;

    // The write takes effect on the access edge; pready is combinational, so zero wait states.
    assign wr_en    = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign rd_setup = apb_req.psel && !apb_req.penable;
    assign hit_ctrl = apb_req.paddr == OSC_CTRL_ADDR;
    assign hit_in   = (apb_req.paddr >= IN_ROUTE_BASE) && (apb_req.paddr < IN_ROUTE_BASE + ROUTE_SPAN);
    assign hit_out  = (apb_req.paddr >= OUT_ROUTE_BASE) && (apb_req.paddr < OUT_ROUTE_BASE + ROUTE_SPAN);
    assign word_idx = {1'b0, apb_req.paddr[7:2]}; // Word within the 256-byte window, not the window's base bit.
    assign route_wr_ok = wr_en && !route_write_lock_reg;
    assign apb_rsp.pready  = apb_req.psel && apb_req.penable;
    assign apb_rsp.pslverr = pslverr_reg;
    assign apb_rsp.prdata  = prdata_reg;

    // Fuse level passes two flops; both reset to the unprogrammed state, which reads as set.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fuse_meta_reg <= FUSE_RESET;
            fuse_reg      <= FUSE_RESET;
        end else begin
            fuse_meta_reg <= single_session_lock_fuse;
            fuse_reg      <= fuse_meta_reg;
        end
    end

    // Pin levels are asynchronous to clk and are synchronised before any routing reads them.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_meta_reg     <= '0;
            pin_sync_reg     <= '0;
            in_only_meta_reg <= 1'b0;
            in_only_sync_reg <= 1'b0;
        end else begin
            pin_meta_reg     <= remappable_io_pin_in;
            pin_sync_reg     <= pin_meta_reg;
            in_only_meta_reg <= remappable_input_pin;
            in_only_sync_reg <= in_only_meta_reg;
        end
    end

    // Unlock sequence: any write that is not the expected next step drops back to idle.
    always_comb begin
        unlock_state_next = unlock_state_reg;
        if (wr_en) begin
            case (unlock_state_reg)
                UNLOCK_IDLE: begin
                    if (hit_ctrl && apb_req.pwdata[7:0] == UNLOCK_KEY_ONE && !(fuse_reg && lock_set_once_reg)) begin
                        unlock_state_next = UNLOCK_KEY1;
                    end
                end
                UNLOCK_KEY1: begin
                    unlock_state_next = (hit_ctrl && apb_req.pwdata[7:0] == UNLOCK_KEY_TWO) ?
                                        UNLOCK_KEY2 : UNLOCK_IDLE;
                end
                default: begin
                    unlock_state_next = UNLOCK_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            unlock_state_reg <= UNLOCK_IDLE;
        end else begin
            unlock_state_reg <= unlock_state_next;
        end
    end

    // Lock bit changes only on the write that completes the sequence, then holds.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            route_write_lock_reg <= LOCK_RESET;
            lock_set_once_reg    <= 1'b0;
        end else begin
            if (wr_en && hit_ctrl && unlock_state_reg == UNLOCK_KEY2) begin
                route_write_lock_reg <= apb_req.pwdata[LOCK_BIT_POS];
            end
            if (route_write_lock_reg) begin
                lock_set_once_reg <= 1'b1;
            end
        end
    end

    // Input selectors: one field per peripheral input, two per register word.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int k = 0; k < NUM_INPUTS; k++) begin
                in_sel_reg[k]    <= IN_SEL_RESET;
                in_shadow_reg[k] <= IN_SEL_RESET;
            end
        end else if (route_wr_ok && hit_in) begin
            for (int k = 0; k < NUM_INPUTS; k++) begin
                if (k / 2 == int'(word_idx)) begin
                    in_sel_reg[k]    <= (k % 2 == 0) ? apb_req.pwdata[FIELD_LO_POS +: SEL_W] :
                                                       apb_req.pwdata[FIELD_HI_POS +: SEL_W];
                    in_shadow_reg[k] <= (k % 2 == 0) ? apb_req.pwdata[FIELD_LO_POS +: SEL_W] :
                                                       apb_req.pwdata[FIELD_HI_POS +: SEL_W];
                end
            end
        end
    end

    // Output selectors: fields of pins beyond the variant's count stay at reset value.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int p = 0; p < MAX_PINS; p++) begin
                out_sel_reg[p]    <= OUT_SEL_RESET;
                out_shadow_reg[p] <= OUT_SEL_RESET;
            end
        end else if (route_wr_ok && hit_out) begin
            for (int p = 0; p < NUM_PINS; p++) begin
                if (p / 2 == int'(word_idx)) begin
                    out_sel_reg[p]    <= (p % 2 == 0) ? apb_req.pwdata[FIELD_LO_POS +: SEL_W] :
                                                        apb_req.pwdata[FIELD_HI_POS +: SEL_W];
                    out_shadow_reg[p] <= (p % 2 == 0) ? apb_req.pwdata[FIELD_LO_POS +: SEL_W] :
                                                        apb_req.pwdata[FIELD_HI_POS +: SEL_W];
                end
            end
        end
    end

    // Shadow compare; only an upset of a stored bit can make the copies differ.
    always_comb begin
        shadow_diff = 1'b0;
        for (int k = 0; k < NUM_INPUTS; k++) begin
            shadow_diff = shadow_diff | (in_sel_reg[k] != in_shadow_reg[k]);
        end
        for (int p = 0; p < MAX_PINS; p++) begin
            shadow_diff = shadow_diff | (out_sel_reg[p] != out_shadow_reg[p]);
        end
    end

    // Reset request is a pulse per cycle of mismatch; the sticky flag survives for software.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            config_mismatch_reset <= 1'b0;
            mismatch_seen_reg     <= 1'b0;
        end else begin
            config_mismatch_reset <= shadow_diff;
            if (shadow_diff) begin
                mismatch_seen_reg <= 1'b1;
            end else if (wr_en && apb_req.paddr == STATUS_ADDR && apb_req.pwdata[MISMATCH_POS]) begin
                mismatch_seen_reg <= 1'b0;
            end
        end
    end

    // Input routing: codes naming no implemented pin give a low level.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            periph_in <= '0;
        end else begin
            for (int k = 0; k < NUM_INPUTS; k++) begin
                if (int'(in_sel_reg[k]) < NUM_PINS) begin
                    periph_in[k] <= pin_sync_reg[in_sel_reg[k][4:0]];
                end else if (in_sel_reg[k] == INPUT_ONLY_PIN) begin
                    periph_in[k] <= in_only_sync_reg;
                end else begin
                    periph_in[k] <= 1'b0;
                end
            end
        end
    end

    // One output selector per implemented pin; missing pins never drive.
    for (genvar g = 0; g < MAX_PINS; g++) begin : gen_pin
        if (g < NUM_PINS) begin : gen_used
            pin_out_selector u_sel (
                .clk        (clk),
                .rstn       (rstn),
                .sel        (out_sel_reg[g]),
                .periph_out (periph_out),
                .pin_out    (remappable_io_pin_out[g]),
                .pin_oe     (remappable_io_pin_oe[g])
            );
        end else begin : gen_absent
            assign remappable_io_pin_out[g] = 1'b0;
            assign remappable_io_pin_oe[g]  = 1'b0;
        end
    end

    // Read mux, sampled in the setup cycle so prdata is a flop in the access cycle.
    always_comb begin
        rdata_next = 32'h0000_0000;
        mapped     = 1'b1;
        if (hit_ctrl) begin
            rdata_next[LOCK_BIT_POS] = route_write_lock_reg;
        end else if (apb_req.paddr == OSC_CFG_ADDR) begin
            rdata_next[FUSE_BIT_POS] = fuse_reg;
        end else if (apb_req.paddr == STATUS_ADDR) begin
            rdata_next[MISMATCH_POS] = mismatch_seen_reg;
        end else if (hit_in && apb_req.paddr[1:0] == 2'b00 && int'(word_idx) < IN_REGS) begin
            for (int k = 0; k < NUM_INPUTS; k++) begin
                if (k / 2 == int'(word_idx)) begin
                    rdata_next[(k % 2 == 0 ? FIELD_LO_POS : FIELD_HI_POS) +: SEL_W] = in_sel_reg[k];
                end
            end
        end else if (hit_out && apb_req.paddr[1:0] == 2'b00 && int'(word_idx) < OUT_REGS) begin
            for (int p = 0; p < MAX_PINS; p++) begin
                if (p / 2 == int'(word_idx)) begin
                    rdata_next[(p % 2 == 0 ? FIELD_LO_POS : FIELD_HI_POS) +: SEL_W] = out_sel_reg[p];
                end
            end
        end else begin
            mapped = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (rd_setup) begin
            prdata_reg  <= apb_req.pwrite ? 32'h0000_0000 : rdata_next;
            pslverr_reg <= !mapped;
        end
    end

    // Checks next to the logic they guard.
    property p_locked_write;
        @(posedge clk) disable iff (!rstn)
        (wr_en && route_write_lock_reg && apb_req.paddr == OUT_ROUTE_BASE) |=> $stable(out_sel_reg[0]);
    endproperty
    a_locked_write: assert property (p_locked_write) else $error("locked route write changed a field");

    property p_null_code;
        @(posedge clk) disable iff (!rstn)
        (out_sel_reg[0] == SEL_NULL) |=> !remappable_io_pin_oe[0];
    endproperty
    a_null_code: assert property (p_null_code) else $error("null code drove pin 0");

    property p_route_code_three;
        @(posedge clk) disable iff (!rstn)
        (out_sel_reg[0] == 6'h03) |=> (remappable_io_pin_oe[0] && remappable_io_pin_out[0] == $past(periph_out[3]));
    endproperty
    a_route_code_three: assert property (p_route_code_three) else $error("code 3 not routed");

    property p_gap_code;
        @(posedge clk) disable iff (!rstn)
        (out_sel_reg[0] == 6'h0d || out_sel_reg[0] == 6'h24) |=> !remappable_io_pin_oe[0];
    endproperty
    a_gap_code: assert property (p_gap_code) else $error("unlisted code drove pin 0");

    property p_lock_read;
        @(posedge clk) disable iff (!rstn)
        (rd_setup && !apb_req.pwrite && hit_ctrl) |=> apb_rsp.prdata[LOCK_BIT_POS] == $past(route_write_lock_reg);
    endproperty
    a_lock_read: assert property (p_lock_read) else $error("lock bit read wrong");

    property p_lock_needs_keys;
        @(posedge clk) disable iff (!rstn)
        $changed(route_write_lock_reg) |-> $past(unlock_state_reg == UNLOCK_KEY2 && wr_en && hit_ctrl);
    endproperty
    a_lock_needs_keys: assert property (p_lock_needs_keys) else $error("lock changed without keys");

    property p_break_cancels;
        @(posedge clk) disable iff (!rstn)
        (unlock_state_reg == UNLOCK_KEY1 && wr_en && !(hit_ctrl && apb_req.pwdata[7:0] == UNLOCK_KEY_TWO))
        |=> unlock_state_reg == UNLOCK_IDLE ##1 $stable(route_write_lock_reg);
    endproperty
    a_break_cancels: assert property (p_break_cancels) else $error("broken sequence not cancelled");

    property p_one_way;
        @(posedge clk) disable iff (!rstn)
        (fuse_reg && lock_set_once_reg && route_write_lock_reg) |=> route_write_lock_reg [*2];
    endproperty
    a_one_way: assert property (p_one_way) else $error("one-way lock cleared");

    property p_mismatch;
        @(posedge clk) disable iff (!rstn)
        shadow_diff |=> config_mismatch_reset;
    endproperty
    a_mismatch: assert property (p_mismatch) else $error("mismatch gave no reset request");

    property p_invalid_input;
        @(posedge clk) disable iff (!rstn)
        (in_sel_reg[0] == IN_SEL_RESET) |=> !periph_in[0];
    endproperty
    a_invalid_input: assert property (p_invalid_input) else $error("invalid input code passed a level");

    c_unlock: cover property (@(posedge clk) disable iff (!rstn) unlock_state_reg == UNLOCK_KEY2);
    c_lock_set: cover property (@(posedge clk) disable iff (!rstn) $rose(route_write_lock_reg));
    c_pin_routed: cover property (@(posedge clk) disable iff (!rstn) remappable_io_pin_oe[0]);

endmodule

// ### tb/periph_model.sv
// Peripheral side model: peripheral outputs that change at random every cycle.
`timescale 1ns/1ps
module periph_model (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rstn,
    // Peripheral outputs toward the router.
    output logic      [35:0] periph_out
);
    int          seed = 75901;
    logic [63:0] r;
    // A fresh pattern each cycle, so a wrong code or a stale register shows up.
    always @(posedge clk or negedge rstn) begin
        r = {$random(seed), $random(seed)};
        if (!rstn) periph_out <= '0;
        else periph_out <= r[35:0];
    end
endmodule

// ### tb/tb_remappable_pin_output_router.sv
// Self-checking bench for the remappable pin router.
`timescale 1ns/1ps
module tb_remappable_pin_output_router;
    import pin_route_pkg::*;
    localparam int         NP = 24;
    logic                  clk = 0, rstn = 0, fuse = 0, ionly = 0, mm;
    apb_req_type           req = '0;
    apb_rsp_type           rsp;
    logic [31:0]           pin_in = '0, pout, poe;
    logic [35:0]           po, prev_po;
    logic [DEF_INPUTS-1:0] pin_per;
    logic [32:0]           q[$];
    logic [32:0]           e;
    logic [5:0]            c;
    logic                  v;
    int                    n_errors = 0, n_checks = 0, seed = 75901;

    pin_route_top #(.NUM_PINS(NP), .NUM_INPUTS(DEF_INPUTS)) DUT (.clk(clk), .rstn(rstn), .apb_req(req),
        .apb_rsp(rsp), .single_session_lock_fuse(fuse), .remappable_io_pin_in(pin_in),
        .remappable_input_pin(ionly), .remappable_io_pin_out(pout), .remappable_io_pin_oe(poe),
        .periph_out(po), .periph_in(pin_per), .config_mismatch_reset(mm));
    periph_model PM (.clk(clk), .rstn(rstn), .periph_out(po));

    always #10 clk = ~clk;

    task err(string s);
        n_errors++;
        $display("[ERR] %0t %s", $time, s);
    endtask

    task chk(logic [31:0] got, logic [31:0] exp, string s);
        n_checks++;
        if (got !== exp) err(s);
    endtask

    // One APB transfer; the request stands until pready is seen high.
    task apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        while (rsp.pready !== 1'b1) @(posedge clk);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task wr(logic [11:0] a, logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rd(logic [11:0] a, logic [32:0] x);
        q.push_back(x);
        apb(1'b0, a, 32'h0);
    endtask

    task lock_seq(logic l);
        wr(OSC_CTRL_ADDR, {24'h0, UNLOCK_KEY_ONE});
        wr(OSC_CTRL_ADDR, {24'h0, UNLOCK_KEY_TWO});
        wr(OSC_CTRL_ADDR, {25'h0, l, 6'h0});
    endtask

    // Pins 0 and 1 both carry code c; output is registered from the previous cycle's source.
    task pins;
        repeat (3) @(posedge clk);
        v = (c >= 6'h01 && c <= 6'h0c) || (c >= 6'h10 && c <= 6'h23);
        chk({30'h0, poe[1:0]}, {30'h0, v, v}, "pin enable");
        if (v) chk({30'h0, pout[1:0]}, {30'h0, prev_po[c], prev_po[c]}, "pin level");
    endtask

    task end_sim;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Monitor: each completed read is compared with the oldest noted expectation.
    always @(posedge clk) begin
        prev_po <= po;
        if (rstn && mm !== 1'b0) err("mismatch reset raised");
        if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1) begin
            e = q.pop_front();
            n_checks++;
            if ({rsp.pslverr, rsp.prdata} !== e) err($sformatf("read %h got %h", req.paddr, rsp.prdata));
        end
    end

    initial begin
        #(20 * 8000);
        err("timeout");
        end_sim;
    end

    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        rd(IN_ROUTE_BASE, 33'h3f3f);
        rd(OUT_ROUTE_BASE, 33'h0);
        rd(OSC_CTRL_ADDR, 33'h0);
        rd(OSC_CFG_ADDR, 33'h0);
        rd(12'h300, {1'b1, 32'h0});
        $display("reset test done");
        for (int i = 0; i < 64; i++) begin
            c = 6'(i);
            wr(OUT_ROUTE_BASE, {16'h0, 2'b0, c, 2'b0, c});
            pins;
        end
        wr(OUT_ROUTE_BASE + 12'h030, 32'h0505);
        rd(OUT_ROUTE_BASE + 12'h030, 33'h0);
        chk({24'h0, poe[31:24]}, 32'h0, "missing pin driven");
        $display("output test done");
        for (int i = 0; i < 12; i++) begin
            c = 6'($unsigned($random(seed)) % 38);
            wr(IN_ROUTE_BASE, {16'h0, 2'b0, INPUT_ONLY_PIN, 2'b0, c});
            pin_in <= $random(seed);
            ionly <= 1'($random(seed));
            repeat (6) @(posedge clk);
            v = (c < NP) ? pin_in[c] : (c == 6'h25) ? ionly : 1'b0;
            chk({30'h0, pin_per[1:0]}, {30'h0, ionly, v}, "input route");
        end
        $display("input test done");
        lock_seq(1'b1);
        rd(OSC_CTRL_ADDR, 33'h40);
        wr(OUT_ROUTE_BASE, 32'h0303);
        rd(OUT_ROUTE_BASE, 33'h3f3f);
        wr(OSC_CTRL_ADDR, 32'h46);
        wr(OUT_ROUTE_BASE, 32'h0);
        wr(OSC_CTRL_ADDR, 32'h57);
        wr(OSC_CTRL_ADDR, 32'h0);
        rd(OSC_CTRL_ADDR, 33'h40);
        lock_seq(1'b0);
        wr(OUT_ROUTE_BASE, 32'h0303);
        wr(OUT_ROUTE_BASE + 12'h004, 32'h0404);
        rd(OUT_ROUTE_BASE, 33'h0303);
        rd(OUT_ROUTE_BASE + 12'h004, 33'h0404);
        rd(STATUS_ADDR, 33'h0);
        $display("lock test done");
        fuse <= 1'b1;
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rd(OSC_CFG_ADDR, 33'h20);
        lock_seq(1'b1);
        lock_seq(1'b0);
        rd(OSC_CTRL_ADDR, 33'h40);
        wr(OUT_ROUTE_BASE, 32'h0101);
        rd(OUT_ROUTE_BASE, 33'h0);
        $display("fuse test done");
        end_sim;
    end
endmodule
